// ---- rtl/fbc_file_ram.sv ----
// ==========================================================
// file register array, two ports, registered read data
// ==========================================================
module fbc_file_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  // clock
  input wire logic clk,
  // core port
  input wire logic [AW-1:0] addrA,
  input wire logic weA,
  input wire logic [DW-1:0] wdA,
  output logic [DW-1:0] rdA,
  // software port
  input wire logic [AW-1:0] addrB,
  input wire logic weB,
  input wire logic [DW-1:0] wdB,
  output logic [DW-1:0] rdB
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // core write placed last so it wins a same-address collision
  always_ff @(posedge clk) begin
    if (weB) begin
      mem[addrB] <= wdB;
    end
    if (weA) begin
      mem[addrA] <= wdA;
    end
    rdA <= mem[addrA];
    rdB <= mem[addrB];
  end

endmodule : fbc_file_ram

// ---- rtl/fbc_exec.sv ----
// What this block does
// - carry-clear branch, opcode 1110 0011 plus offset, taken only when carry is 0
// - negative branch, opcode 1110 0110 plus offset, taken only when negative is 1
// - taken branch adds twice the signed 8-bit offset to the program counter
// - target is branch address plus 2 plus twice the offset
// - taken branch costs a second all-idle cycle; not taken writes no counter
// - bit clear zeroes bit b of file f, no flags; access bit picks bank
// - access bit 0 with extended set and f up to 95 uses indexed offset
// ==========================================================
// constants
// ==========================================================
package fbc_pkg;
  localparam logic [3:0] OP_BRANCH_HI = 4'he;
  localparam logic [3:0] OP_CARRY_CLR_LO = 4'h3;
  localparam logic [3:0] OP_NEG_SET_LO = 4'h6;
  localparam logic [3:0] OP_BIT_CLR_HI = 4'h9;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam int DATA_AW = 12;
  localparam logic [7:0] ACCESS_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  // apb map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BANK = 8'h04;
  localparam logic [7:0] ADDR_IDXBASE = 8'h08;
  localparam logic [7:0] ADDR_PC = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MEMADDR = 8'h14;
  localparam logic [7:0] ADDR_MEMDATA = 8'h18;
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [3:0] BANK_RESET = 4'h0;
  localparam logic [11:0] IDXBASE_RESET = 12'h000;
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } fbc_phase_t;
endpackage : fbc_pkg

// ==========================================================
// execute unit
// ==========================================================
module fbc_exec #(
  parameter int PC_W = 21
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  input wire logic [15:0] instrWord,
  input wire logic carryFlag,
  input wire logic negFlag,
  output logic [PC_W-1:0] pcOut,
  output logic [1:0] phaseOut,
  output logic stallOut
);

  // ==========================================================
  // state
  // ==========================================================
  fbc_pkg::fbc_phase_t phase_r;
  fbc_pkg::fbc_phase_t phase_nxt;
  logic [PC_W-1:0] pc_r;
  logic [15:0] instr_r;
  logic stall_r;
  logic lastTaken_r;
  logic [1:0] ctrl_r;
  logic [3:0] bank_r;
  logic [11:0] idxBase_r;
  logic [11:0] memAddr_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  // ==========================================================
  // decode
  // ==========================================================
  wire run = ctrl_r[fbc_pkg::CTRL_RUN_BIT];
  wire extEn = ctrl_r[fbc_pkg::CTRL_EXT_BIT];
  wire isBnc = instr_r[15:8] == {fbc_pkg::OP_BRANCH_HI, fbc_pkg::OP_CARRY_CLR_LO};
  wire isBn = instr_r[15:8] == {fbc_pkg::OP_BRANCH_HI, fbc_pkg::OP_NEG_SET_LO};
  wire isBcf = instr_r[15:12] == fbc_pkg::OP_BIT_CLR_HI;
  wire [7:0] brOffset = instr_r[7:0];
  wire [2:0] bitSel = instr_r[11:9];
  wire accSel = instr_r[8];
  wire [7:0] fAddr = instr_r[7:0];
  wire lowFile = fAddr <= fbc_pkg::ACCESS_LIMIT;
  wire taken = (isBnc & ~carryFlag) | (isBn & negFlag);
  // pc already points past the branch, so only the doubled offset is added
  wire [PC_W-1:0] targetPc = pc_r + {{(PC_W-9){brOffset[7]}}, brOffset, 1'b0};
  wire atQ1 = run & (phase_r == fbc_pkg::PH_Q1);
  wire atQ4 = run & (phase_r == fbc_pkg::PH_Q4);

  // ==========================================================
  // file address and read-modify-write
  // ==========================================================
  wire [11:0] effAddr = accSel ? {bank_r, fAddr} :
    (extEn & lowFile) ? idxBase_r + {4'h0, fAddr} :
    lowFile ? {4'h0, fAddr} : {fbc_pkg::ACCESS_HIGH_BANK, fAddr};
  wire [7:0] rdA;
  wire [7:0] rdB;
  wire weA = isBcf & atQ4;
  wire [7:0] wdA = rdA & ~(8'h01 << bitSel);

  // ==========================================================
  // apb decode
  // ==========================================================
  wire apbAcc = psel & penable & ~pready_r;
  wire wrEn = psel & penable & pready_r & pwrite;
  wire pcWr = wrEn & (paddr == fbc_pkg::ADDR_PC);
  wire mapped = (paddr == fbc_pkg::ADDR_CTRL) | (paddr == fbc_pkg::ADDR_BANK) |
    (paddr == fbc_pkg::ADDR_IDXBASE) | (paddr == fbc_pkg::ADDR_PC) |
    (paddr == fbc_pkg::ADDR_STATUS) | (paddr == fbc_pkg::ADDR_MEMADDR) |
    (paddr == fbc_pkg::ADDR_MEMDATA);
  wire [31:0] rdMux =
    (paddr == fbc_pkg::ADDR_CTRL) ? {30'h0000_0000, ctrl_r} :
    (paddr == fbc_pkg::ADDR_BANK) ? {28'h000_0000, bank_r} :
    (paddr == fbc_pkg::ADDR_IDXBASE) ? {20'h0_0000, idxBase_r} :
    (paddr == fbc_pkg::ADDR_PC) ? {{(32-PC_W){1'b0}}, pc_r} :
    (paddr == fbc_pkg::ADDR_STATUS) ? {28'h000_0000, lastTaken_r, stall_r, phase_r} :
    (paddr == fbc_pkg::ADDR_MEMADDR) ? {20'h0_0000, memAddr_r} :
    (paddr == fbc_pkg::ADDR_MEMDATA) ? {24'h00_0000, rdB} : 32'h0000_0000;
  wire weB = wrEn & (paddr == fbc_pkg::ADDR_MEMDATA);

  fbc_file_ram #(
    .AW(fbc_pkg::DATA_AW),
    .DW(8)
  ) u_ram (
    .clk(mclk),
    .addrA(effAddr),
    .weA(weA),
    .wdA(wdA),
    .rdA(rdA),
    .addrB(memAddr_r),
    .weB(weB),
    .wdB(pwdata[7:0]),
    .rdB(rdB)
  );

  // ==========================================================
  // phase sequencer
  // ==========================================================
  always_comb begin
    unique case (phase_r)
      fbc_pkg::PH_Q1: phase_nxt = fbc_pkg::PH_Q2;
      fbc_pkg::PH_Q2: phase_nxt = fbc_pkg::PH_Q3;
      fbc_pkg::PH_Q3: phase_nxt = fbc_pkg::PH_Q4;
      fbc_pkg::PH_Q4: phase_nxt = fbc_pkg::PH_Q1;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= fbc_pkg::PH_Q1;
    end else if (run) begin
      phase_r <= phase_nxt;
    end
  end

  // ==========================================================
  // fetch, branch and stall
  // ==========================================================
  // the stall cycle latches a nop word so nothing downstream acts on it
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      instr_r <= fbc_pkg::NOP_WORD;
      stall_r <= 1'b0;
      lastTaken_r <= 1'b0;
    end else if (atQ1) begin
      instr_r <= stall_r ? fbc_pkg::NOP_WORD : instrWord;
      stall_r <= 1'b0;
    end else if (atQ4 & (isBnc | isBn)) begin
      stall_r <= taken;
      lastTaken_r <= taken;
    end
  end

  // software load of the counter wins over the core
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pc_r <= '0;
    end else if (pcWr) begin
      pc_r <= pwdata[PC_W-1:0];
    end else if (atQ1 & ~stall_r) begin
      pc_r <= pc_r + PC_W'(2);
    end else if (atQ4 & taken) begin
      pc_r <= targetPc;
    end
  end

  // ==========================================================
  // apb registers
  // ==========================================================
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= fbc_pkg::CTRL_RESET;
      bank_r <= fbc_pkg::BANK_RESET;
      idxBase_r <= fbc_pkg::IDXBASE_RESET;
      memAddr_r <= 12'h000;
    end else if (wrEn) begin
      if (paddr == fbc_pkg::ADDR_CTRL) ctrl_r <= pwdata[1:0];
      if (paddr == fbc_pkg::ADDR_BANK) bank_r <= pwdata[3:0];
      if (paddr == fbc_pkg::ADDR_IDXBASE) idxBase_r <= pwdata[11:0];
      if (paddr == fbc_pkg::ADDR_MEMADDR) memAddr_r <= pwdata[11:0];
    end
  end

  // one wait state: ram read data settle before the answer
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= apbAcc;
      pslverr_r <= apbAcc & ~mapped;
      if (apbAcc) prdata_r <= rdMux;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pcOut = pc_r;
  assign phaseOut = phase_r;
  assign stallOut = stall_r;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_carry_clear_branch;
    atQ4 & isBnc & ~pcWr |=> pc_r == ($past(carryFlag) ? $past(pc_r) : $past(targetPc));
  endproperty
  a_carry_clear_branch: assert property (p_carry_clear_branch)
    else $error("carry-clear branch wrote wrong counter");

  property p_negative_branch;
    atQ4 & isBn & ~pcWr |=> pc_r == ($past(negFlag) ? $past(targetPc) : $past(pc_r));
  endproperty
  a_negative_branch: assert property (p_negative_branch)
    else $error("negative branch wrote wrong counter");

  property p_target_math;
    atQ1 & ~stall_r & ~pcWr & (instrWord[15:12] == fbc_pkg::OP_BRANCH_HI) ##1
      (~pcWr)[*3] ##0 taken |=> pc_r ==
      $past(pc_r, 4) + PC_W'(2) + {{(PC_W-9){instr_r[7]}}, instr_r[7:0], 1'b0};
  endproperty
  a_target_math: assert property (p_target_math)
    else $error("branch target not address plus two plus twice offset");

  property p_taken_idle;
    atQ4 & taken & ~pcWr |=> (atQ1 & stall_r) ##1 instr_r == fbc_pkg::NOP_WORD;
  endproperty
  a_taken_idle: assert property (p_taken_idle)
    else $error("taken branch not followed by an idle cycle");

  property p_stall_no_advance;
    atQ1 & stall_r & ~pcWr |=> $stable(pc_r) && !stall_r;
  endproperty
  a_stall_no_advance: assert property (p_stall_no_advance)
    else $error("counter moved during idle cycle");

  property p_bit_clear_value;
    weA |-> (wdA[bitSel] == 1'b0) && ((wdA | (8'h01 << bitSel)) == (rdA | (8'h01 << bitSel)));
  endproperty
  a_bit_clear_value: assert property (p_bit_clear_value)
    else $error("bit clear changed wrong bits");

  property p_bank_select;
    isBcf & accSel |-> effAddr == {bank_r, fAddr};
  endproperty
  a_bank_select: assert property (p_bank_select)
    else $error("banked file address wrong");

  property p_indexed;
    isBcf & ~accSel & lowFile |-> effAddr == (extEn ? idxBase_r + {4'h0, fAddr} : {4'h0, fAddr});
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed offset address wrong");

  property p_rmw_phase;
    weA |-> $past(phase_r, 2) == fbc_pkg::PH_Q2 && $stable(effAddr);
  endproperty
  a_rmw_phase: assert property (p_rmw_phase)
    else $error("bit clear write not in last phase");

endmodule : fbc_exec

// ---- verification/tb.sv ----
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // signals
  // ==========================================================
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] instrWord = 16'h0000;
  logic carryFlag = 1'b0;
  logic negFlag = 1'b0;
  logic [20:0] pcOut;
  logic [1:0] phaseOut;
  logic stallOut;
  logic [15:0] prog [256];
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int checks_done = 0;

  fbc_exec #(.PC_W(21)) dut (.mclk(mclk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instrWord(instrWord), .carryFlag(carryFlag), .negFlag(negFlag),
    .pcOut(pcOut), .phaseOut(phaseOut), .stallOut(stallOut));

  always #20 mclk = ~mclk;
  // program memory answers the fetch address, one edge behind
  always @(posedge mclk) instrWord <= prog[pcOut[8:1]];

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic timeout;
    num_errors++;
    $display("CHECK FAILED wait expected done seen timeout");
    summarize();
  endtask : timeout

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) timeout();
  endtask : apb

  // waits for a program counter value, or for a phase when byPc is low
  task automatic waitCore(input logic [20:0] v, input bit byPc);
    for (int i = 0; i < 200; i++) begin
      @(posedge mclk);
      #1;
      if ((byPc && pcOut === v) || (!byPc && phaseOut === v[1:0])) return;
    end
    timeout();
  endtask : waitCore

  task automatic doReset;
    rst_b <= 1'b0;
    foreach (prog[i]) prog[i] = fbc_pkg::NOP_WORD;
    repeat (9) @(posedge mclk);
    #1;
    check("reset pc", pcOut, 32'h0000_0000);
    check("reset phase", phaseOut, 32'h0000_0000);
    check("reset stall", stallOut, 32'h0000_0000);
    @(posedge mclk);
    rst_b <= 1'b1;
  endtask : doReset

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic regs;
    logic [7:0] a [4] = '{fbc_pkg::ADDR_CTRL, fbc_pkg::ADDR_BANK, fbc_pkg::ADDR_IDXBASE,
      fbc_pkg::ADDR_PC};
    doReset();
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0000_0000);
      check("reset reg", rd, 32'h0000_0000);
    end
    apb(1'b0, 8'h20, 32'h0000_0000);
    check("unmapped read err", er, 32'h0000_0001);
    check("unmapped read data", rd, 32'h0000_0000);
    apb(1'b1, 8'h24, 32'h0000_0005);
    check("unmapped write err", er, 32'h0000_0001);
  endtask : regs

  task automatic branch(input logic [3:0] lo, input logic c, input logic ng,
      input logic [20:0] p, input logic [7:0] n, input logic tk);
    logic [20:0] tgt;
    tgt = p + 21'd2 + {{12{n[7]}}, n, 1'b0};
    doReset();
    prog[p[8:1]] = {fbc_pkg::OP_BRANCH_HI, lo, n};
    carryFlag <= c;
    negFlag <= ng;
    apb(1'b1, fbc_pkg::ADDR_PC, 32'(p));
    apb(1'b1, fbc_pkg::ADDR_CTRL, 32'h1 << fbc_pkg::CTRL_RUN_BIT);
    waitCore(p + 21'd2, 1'b1);
    waitCore(21'(fbc_pkg::PH_Q1), 1'b0);
    check("branch pc", pcOut, tk ? tgt : p + 21'd2);
    check("stall", stallOut, tk);
    if (tk) begin
      waitCore(21'(fbc_pkg::PH_Q2), 1'b0);
      check("stall pc held", pcOut, tgt);
      check("stall end", stallOut, 32'h0000_0000);
    end
    apb(1'b0, fbc_pkg::ADDR_STATUS, 32'h0000_0000);
    check("taken status", rd[3], tk);
  endtask : branch

  task automatic bitclr(input logic ext, input logic a, input logic [3:0] bank,
      input logic [11:0] idx, input logic [7:0] f, input logic [2:0] b, input logic [11:0] ra);
    doReset();
    prog[8'h20] = {fbc_pkg::OP_BIT_CLR_HI, b, a, f};
    apb(1'b1, fbc_pkg::ADDR_BANK, 32'(bank));
    apb(1'b1, fbc_pkg::ADDR_IDXBASE, 32'(idx));
    apb(1'b1, fbc_pkg::ADDR_MEMADDR, 32'(ra));
    apb(1'b1, fbc_pkg::ADDR_MEMDATA, 32'h0000_00ff);
    apb(1'b1, fbc_pkg::ADDR_PC, 32'h0000_0040);
    apb(1'b1, fbc_pkg::ADDR_CTRL,
      (32'h1 << fbc_pkg::CTRL_RUN_BIT) | (32'(ext) << fbc_pkg::CTRL_EXT_BIT));
    waitCore(21'h00_0042, 1'b1);
    waitCore(21'(fbc_pkg::PH_Q1), 1'b0);
    check("one cycle", stallOut, 32'h0000_0000);
    apb(1'b0, fbc_pkg::ADDR_MEMDATA, 32'h0000_0000);
    check("cleared byte", rd[7:0], 8'hff & ~(8'h01 << b));
    apb(1'b0, fbc_pkg::ADDR_BANK, 32'h0000_0000);
    check("bank readback", rd, 32'(bank));
  endtask : bitclr

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    regs();
    branch(fbc_pkg::OP_CARRY_CLR_LO, 1'b0, 1'b0, 21'h00_0040, 8'h05, 1'b1);
    branch(fbc_pkg::OP_CARRY_CLR_LO, 1'b1, 1'b1, 21'h00_0040, 8'h05, 1'b0);
    branch(fbc_pkg::OP_CARRY_CLR_LO, 1'b0, 1'b0, 21'h00_0180, 8'h80, 1'b1);
    branch(fbc_pkg::OP_CARRY_CLR_LO, 1'b0, 1'b1, 21'h00_0040, 8'h7f, 1'b1);
    branch(fbc_pkg::OP_NEG_SET_LO, 1'b1, 1'b1, 21'h00_0100, 8'hfd, 1'b1);
    branch(fbc_pkg::OP_NEG_SET_LO, 1'b0, 1'b0, 21'h00_0100, 8'hfd, 1'b0);
    bitclr(1'b0, 1'b1, 4'h3, 12'h000, 8'ha5, 3'd7, 12'h3a5);
    bitclr(1'b0, 1'b0, 4'h3, 12'h200, 8'h5f, 3'd0, 12'h05f);
    bitclr(1'b0, 1'b0, 4'h3, 12'h000, 8'h60, 3'd3, 12'hf60);
    bitclr(1'b1, 1'b0, 4'h0, 12'h200, 8'h5f, 3'd5, 12'h25f);
    bitclr(1'b1, 1'b0, 4'h0, 12'hff0, 8'h20, 3'd2, 12'h010);
    bitclr(1'b1, 1'b0, 4'h0, 12'h200, 8'h60, 3'd4, 12'hf60);
    bitclr(1'b1, 1'b1, 4'h2, 12'h200, 8'h10, 3'd1, 12'h210);
    summarize();
  end
endmodule : tb
